// [asr_ctrl.sv]
// Host controller driving an asynchronous 1M x 8 static memory.
`timescale 1ns/1ps
module asr_ctrl
    import asr_pkg::*;
#(
    parameter int RD_CYCLES = RD_CYC,
    parameter int WR_CYCLES = WR_CYC
)
(
    input  wire logic              clk,          // 10 MHz clock.
    input  wire logic              nrst,         // Asynchronous reset, active low.
    input  wire logic              ce,           // Clock enable, freezes state.
    input  wire logic              reqValid,     // Request present.
    output logic                   reqReady,     // Request taken this cycle.
    input  wire logic              reqWrite,     // 1 write, 0 read.
    input  wire logic [ADDR_W-1:0] reqAddr,      // Word address.
    input  wire logic [DATA_W-1:0] reqWdata,     // Write byte.
    output logic                   rspValid,     // Read data valid pulse.
    output logic [DATA_W-1:0]      rspRdata,     // Read byte.
    output logic [ADDR_W-1:0]      addrLines,    // SRAM address.
    output logic                   selectOne_n,  // Select, active low.
    output logic                   selectTwo,    // Select, active high.
    output logic                   outGate_n,    // Output gate, active low.
    output logic                   writeStrobe_n,// Write strobe, active low.
    output logic [DATA_W-1:0]      dataPinsOut,  // Data to pins.
    output logic                   dataPinsOe,   // Host drives data pins.
    input  wire logic [DATA_W-1:0] dataPinsIn    // Data from pins.
);
    ////////////////////////////////////////////////////////////////////////
    asr_state_t        state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              write_q;
    logic [DATA_W-1:0] din1_q;
    logic [DATA_W-1:0] din2_q;
    asr_pins_if        pif ();

    assign reqReady = (state_q == ASR_IDLE) && ce;

    function automatic logic [CNT_W-1:0] CNT_CAST(input int v);
        CNT_CAST = v[CNT_W-1:0];
    endfunction : CNT_CAST

    // Pin data is asynchronous to clk, so it passes two flops first.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            din1_q <= '0;
            din2_q <= '0;
        end
        else if (ce)
        begin
            din1_q <= dataPinsIn;
            din2_q <= din1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ASR_IDLE;
            cnt_q   <= CNT_ZERO;
            addr_q  <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
        end
        else if (ce)
        begin
            case (state_q)
                ASR_IDLE:
                begin
                    if (reqValid)
                    begin
                        addr_q  <= reqAddr;
                        wdata_q <= reqWdata;
                        write_q <= reqWrite;
                        state_q <= ASR_SETUP;
                    end
                end
                ASR_SETUP:
                begin
                    // Address reaches the pins one cycle before any select.
                    cnt_q   <= write_q ? CNT_CAST(WR_CYCLES) : CNT_CAST(RD_CYCLES + 2);
                    state_q <= write_q ? ASR_WRITE : ASR_READ;
                end
                ASR_READ, ASR_WRITE:
                begin
                    if (cnt_q == CNT_ONE)
                        state_q <= ASR_HOLD;
                    else
                        cnt_q <= cnt_q - CNT_ONE;
                end
                ASR_HOLD:
                    state_q <= ASR_IDLE;
                default:
                    state_q <= ASR_IDLE;
            endcase
        end
    end

    // Read data is taken in the hold cycle: only then has the second synchroniser
    // flop seen a byte that the memory drove for a whole cycle, while the gate
    // is still low. Taking it one cycle earlier would catch the released bus.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rspValid <= 1'b0;
            rspRdata <= '0;
        end
        else if (ce)
        begin
            rspValid <= (state_q == ASR_HOLD) && !write_q;
            if ((state_q == ASR_HOLD) && !write_q)
                rspRdata <= din2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selects stay active through HOLD so the write ends on the strobe edge
    // while data is still driven; this gives data hold after the end edge.
    assign pif.addr  = addr_q;
    assign pif.wdata = wdata_q;
    assign pif.sel   = (state_q == ASR_READ) || (state_q == ASR_WRITE) || (state_q == ASR_HOLD);
    assign pif.wr    = (state_q == ASR_WRITE);
    assign pif.rd    = (state_q == ASR_READ);
    assign pif.drive = write_q && (state_q != ASR_IDLE);

    asr_pin_stage u_pins (
        .clk           (clk),
        .nrst          (nrst),
        .ce            (ce),
        .pi            (pif),
        .addrLines     (addrLines),
        .selectOne_n   (selectOne_n),
        .selectTwo     (selectTwo),
        .outGate_n     (outGate_n),
        .writeStrobe_n (writeStrobe_n),
        .dataPinsOut   (dataPinsOut),
        .dataPinsOe    (dataPinsOe)
    );

    ////////////////////////////////////////////////////////////////////////
    addr_stable_a: assert property (@(posedge clk) disable iff (!nrst)
        (!selectOne_n && $past(!selectOne_n)) |-> $stable(addrLines))
        else $error("address moved while selected");
    data_before_a: assert property (@(posedge clk) disable iff (!nrst)
        !writeStrobe_n |-> dataPinsOe) else $error("write without data driven");
    data_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(writeStrobe_n) |-> dataPinsOe && $stable(dataPinsOut))
        else $error("data changed at write end");
    desel_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        selectOne_n |-> (writeStrobe_n && outGate_n)) else $error("strobe while deselected");
    write_len_a: assert property (@(posedge clk) disable iff (!nrst)
        $fell(writeStrobe_n) |-> !writeStrobe_n [*1] ##1 writeStrobe_n)
        else $error("write pulse length wrong");
    read_resp_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
        (reqValid && reqReady && !reqWrite) |-> ##[4:8] rspValid)
        else $error("read answer missing");
    sel_pair_a: assert property (@(posedge clk) disable iff (!nrst)
        selectOne_n == !selectTwo) else $error("selects disagree");

    rd_cov: cover property (@(posedge clk) disable iff (!nrst) rspValid);
    wr_cov: cover property (@(posedge clk) disable iff (!nrst) $rose(writeStrobe_n));
    b2b_cov: cover property (@(posedge clk) disable iff (!nrst) rspValid ##[1:4] !writeStrobe_n);
endmodule : asr_ctrl

// [asr_pkg.sv]
// Package with constants and types for the async SRAM host controller.
// Behaviour
// - Write strobe level picks access direction.
// - Host holds write strobe high when reading.
// - Write ends when any control goes inactive.
// - Write data valid around the ending edge.
// - Address stable before selects become active.
package asr_pkg;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 8;
    localparam int CLK_PERIOD_NS = 100;
    // Read cycle time and write pulse width, in ns.
    localparam int T_RC_NS       = 55;
    localparam int T_PWE_NS      = 40;
    // Strobe to high-impedance of device outputs, in ns.
    localparam int T_HZWE_NS     = 25;
    localparam int RD_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC  = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC  = (T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W   = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    typedef enum logic [2:0] {ASR_IDLE, ASR_SETUP, ASR_READ, ASR_WRITE, ASR_HOLD} asr_state_t;
endpackage : asr_pkg

// [asr_pins_if.sv]
// Interface bundling the pin-side strobes between controller core and pin stage.
`timescale 1ns/1ps
interface asr_pins_if;
    import asr_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              sel;
    logic              wr;
    logic              rd;
    logic              drive;
    modport core (output addr, wdata, sel, wr, rd, drive);
    modport pins (input addr, wdata, sel, wr, rd, drive);
endinterface : asr_pins_if

// [asr_pin_stage.sv]
// Registered pin stage that turns core strobes into SRAM control levels.
`timescale 1ns/1ps
module asr_pin_stage
    import asr_pkg::*;
(
    input  wire logic              clk,          // System clock.
    input  wire logic              nrst,         // Asynchronous reset, active low.
    input  wire logic              ce,           // Clock enable.
    asr_pins_if.pins               pi,           // Strobes from the core.
    output logic [ADDR_W-1:0]      addrLines,    // SRAM address.
    output logic                   selectOne_n,  // Select, active low.
    output logic                   selectTwo,    // Select, active high.
    output logic                   outGate_n,    // Output gate, active low.
    output logic                   writeStrobe_n,// Write strobe, active low.
    output logic [DATA_W-1:0]      dataPinsOut,  // Data driven to pins.
    output logic                   dataPinsOe    // High while host drives data.
);
    // All pins come from flops so no glitch can open a spurious write window.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addrLines     <= '0;
            selectOne_n   <= 1'b1;
            selectTwo     <= 1'b0;
            outGate_n     <= 1'b1;
            writeStrobe_n <= 1'b1;
            dataPinsOut   <= '0;
            dataPinsOe    <= 1'b0;
        end
        else if (ce)
        begin
            addrLines     <= pi.addr;
            selectOne_n   <= !pi.sel;
            selectTwo     <= pi.sel;
            writeStrobe_n <= !pi.wr;
            outGate_n     <= !(pi.rd && !pi.wr);
            dataPinsOut   <= pi.wdata;
            dataPinsOe    <= pi.drive;
        end
    end

    strobe_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        !(!writeStrobe_n && !outGate_n)) else $error("gate and strobe both low");
    write_qual_a: assert property (@(posedge clk) disable iff (!nrst)
        !writeStrobe_n |-> (!selectOne_n && selectTwo)) else $error("write without select");
endmodule : asr_pin_stage

// [asr_sram_model.sv]
// Behavioural model of the 1M x 8 asynchronous static memory.
`timescale 1ns/1ps
module asr_sram_model
    import asr_pkg::*;
(
    input  wire logic              clk,          // Paces the float pattern only.
    input  wire logic [ADDR_W-1:0] addrLines,    // Address.
    input  wire logic              selectOne_n,  // Select, active low.
    input  wire logic              selectTwo,    // Select, active high.
    input  wire logic              outGate_n,    // Output gate, active low.
    input  wire logic              writeStrobe_n,// Write strobe, active low.
    input  wire logic [DATA_W-1:0] busIn,        // Resolved data pins.
    output logic [DATA_W-1:0]      memData,      // Driven byte or float pattern.
    output logic                   memDrive      // High while the model drives.
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] floatPat = 8'h5a;
    logic              armed    = 1'b0;
    wire  logic        chipOn   = !selectOne_n && selectTwo;
    wire  logic        writing  = chipOn && !writeStrobe_n;
    assign memDrive = chipOn && writeStrobe_n && !outGate_n;
    always @(posedge clk) floatPat <= floatPat + 8'h01;
    // Data is taken at whichever edge closes the overlap, not when it opens.
    always @(writing)
    begin
        if (writing === 1'b1) armed = 1'b1;
        else if (armed)
        begin
            mem[addrLines] = busIn;
            armed = 1'b0;
        end
    end
    // A released bus shows a changing pattern so a stale byte can never pass.
    always @*
    begin
        if (!memDrive) memData = floatPat;
        else if (mem.exists(addrLines)) memData = mem[addrLines];
        else memData = ~addrLines[DATA_W-1:0];
    end
endmodule : asr_sram_model

// [asr_ctrl_tb_top.sv]
// Self-checking testbench for the asynchronous static memory host controller.
`timescale 1ns/1ps
module asr_ctrl_tb_top;
    import asr_pkg::*;
    logic clk = 1'b0, nrst, ce, reqValid, reqWrite, reqReady, rspValid;
    logic selectOne_n, selectTwo, outGate_n, writeStrobe_n, dataPinsOe, memDrive;
    logic [ADDR_W-1:0] reqAddr, addrLines;
    logic [DATA_W-1:0] reqWdata, rspRdata, dataPinsOut, dataPinsIn, memData;
    int fail_count = 0;
    int checked    = 0;
    assign dataPinsIn = dataPinsOe ? dataPinsOut : memData;
    asr_ctrl DUT (.clk(clk), .nrst(nrst), .ce(ce), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid),
        .rspRdata(rspRdata), .addrLines(addrLines), .selectOne_n(selectOne_n),
        .selectTwo(selectTwo), .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n),
        .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe), .dataPinsIn(dataPinsIn));
    asr_sram_model mem0 (.clk(clk), .addrLines(addrLines), .selectOne_n(selectOne_n),
        .selectTwo(selectTwo), .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n),
        .busIn(dataPinsIn), .memData(memData), .memDrive(memDrive));
    initial forever #(CLK_PERIOD_NS/2) clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic expect_ok(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : expect_ok
    task automatic send(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #5;
        reqWrite = wr;
        reqAddr  = a;
        reqWdata = d;
        reqValid = 1'b1;
        for (int i = 0; i < 20 && reqReady !== 1'b1; i++)
        begin
            @(posedge clk);
            #5;
        end
        @(posedge clk);
        #5 reqValid = 1'b0;
    endtask : send
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        send(1'b1, a, d);
        repeat (5)
        begin
            @(negedge clk);
            if (!writeStrobe_n) expect_ok(dataPinsOe && !selectOne_n && selectTwo, "wr");
        end
        expect_ok(selectOne_n === 1'b1 && selectTwo === 1'b0, "not deselected");
    endtask : do_write
    task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        send(1'b0, a, 8'h00);
        for (n = 0; n < 10 && rspValid !== 1'b1; n++)
        begin
            @(negedge clk);
            expect_ok(writeStrobe_n === 1'b1 && dataPinsOe === 1'b0, "read pins");
        end
        expect_ok(n < 10 && rspRdata === exp, "read data");
    endtask : do_read
    // A read is taken, then the enable drops before the selects can go active.
    task automatic test_freeze;
        int n;
        send(1'b0, 20'hfffff, 8'h00);
        ce = 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            #5;
            expect_ok(reqReady === 1'b0 && selectOne_n === 1'b1 && rspValid === 1'b0, "ce frozen");
        end
        ce = 1'b1;
        for (n = 0; n < 10 && rspValid !== 1'b1; n++) @(negedge clk);
        expect_ok(n < 10 && rspRdata === 8'h3c, "read after freeze");
    endtask : test_freeze
    always @(negedge clk) if (dataPinsOe === 1'b1) expect_ok(!memDrive, "contention");
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("Counts: checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial
    begin
        #(3000 * CLK_PERIOD_NS);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
    initial
    begin
        {nrst, reqValid, reqWrite, reqAddr, reqWdata} = '0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        #5 nrst = 1'b1;
        expect_ok(selectOne_n && !selectTwo && outGate_n && writeStrobe_n && !dataPinsOe, "rst");
        $display("test reset done");
        // Both ends of the address range plus a checkerboard address.
        do_write(20'h00000, 8'ha5);
        do_write(20'hfffff, 8'h3c);
        do_write(20'h55555, 8'h00);
        do_read(20'h00000, 8'ha5);
        do_read(20'hfffff, 8'h3c);
        do_read(20'h55555, 8'h00);
        $display("test edges done");
        do_write(20'h12345, 8'h11);
        do_write(20'h12345, 8'hee);
        do_read(20'h12345, 8'hee);
        $display("test overwrite done");
        test_freeze();
        $display("test clock enable done");
        print_verdict();
    end
endmodule : asr_ctrl_tb_top
